/* rtl/spfs_pkg.sv */
/*
 Package for the self-programming flash sequencer: register offset, bit
 positions, reset value, address geometry, timing constants and carriers.
 Assumes a 100 MHz CPU clock.
*/
package spfs_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] SPFS_CSR_OFFSET  = 8'h37;
   localparam logic [7:0] SPFS_CSR_RESET   = 8'h00;
   localparam int         SPFS_BIT_IRQEN   = 7;
   localparam int         SPFS_BIT_BUSY    = 6;
   localparam int         SPFS_BIT_RSVD    = 5;
   localparam int         SPFS_BIT_REEN    = 4;
   localparam int         SPFS_BIT_LOCK    = 3;
   localparam int         SPFS_BIT_WRITE   = 2;
   localparam int         SPFS_BIT_ERASE   = 1;
   localparam int         SPFS_BIT_ENABLE  = 0;
   // Accepted lower five-bit command patterns
   localparam logic [4:0] SPFS_PAT_REEN    = 5'h11;
   localparam logic [4:0] SPFS_PAT_LOCK    = 5'h09;
   localparam logic [4:0] SPFS_PAT_WRITE   = 5'h05;
   localparam logic [4:0] SPFS_PAT_ERASE   = 5'h03;
   localparam logic [4:0] SPFS_PAT_FILL    = 5'h01;

   // ---------------------------------------------------------------
   // Flash geometry
   // ---------------------------------------------------------------
   localparam int          SPFS_PC_W       = 14;
   localparam int          SPFS_WORD_W     = 6;
   localparam int          SPFS_PAGE_W     = 8;
   localparam int          SPFS_PAGE_LSB   = 7;
   localparam int          SPFS_WORD_LSB   = 1;
   localparam logic [13:0] SPFS_STALL_BASE = 14'h3800;
   localparam logic [13:0] SPFS_BOOT_11    = 14'h3f00;
   localparam logic [13:0] SPFS_BOOT_10    = 14'h3e00;
   localparam logic [13:0] SPFS_BOOT_01    = 14'h3c00;
   localparam logic [13:0] SPFS_BOOT_00    = 14'h3800;
   localparam logic [5:0]  SPFS_PAGES_11   = 6'h04;
   localparam logic [5:0]  SPFS_PAGES_10   = 6'h08;
   localparam logic [5:0]  SPFS_PAGES_01   = 6'h10;
   localparam logic [5:0]  SPFS_PAGES_00   = 6'h20;
   localparam logic [7:0]  SPFS_LOCK_RESET = 8'hff;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SPFS_CLK_MHZ      = 100;
   localparam int SPFS_WINDOW_CYC   = 4;
   localparam int SPFS_READ_WIN_CYC = 3;
   localparam int SPFS_PROG_MIN_US  = 3700;
   localparam int SPFS_PROG_MAX_US  = 4500;
   // Aim at the lower of the two bounds, the least time in whole cycles
   localparam int SPFS_PROG_CYC     = SPFS_PROG_MIN_US * SPFS_CLK_MHZ;

   typedef enum logic [2:0] {
      SPFS_OP_NONE, SPFS_OP_FILL, SPFS_OP_ERASE, SPFS_OP_WRITE, SPFS_OP_LOCK,
      SPFS_OP_REEN
   } spfs_op_e;

   // Flash array command carrier
   typedef struct packed {
      logic        erase;
      logic        write;
      logic        lock;
      logic [7:0]  page;
      logic [7:0]  lock_data;
   } spfs_flash_cmd_s;

   // Buffer fill carrier
   typedef struct packed {
      logic        wr;
      logic        clear;
      logic [5:0]  word;
      logic [15:0] data;
   } spfs_buf_cmd_s;
endpackage : spfs_pkg

/* rtl/spfs_sequencer.sv */
/*
 Self-programming flash sequencer: control/status register, command
 window, page buffer, erase/write timing, section busy and CPU halt.
 Assumes the CPU core presents register writes, store and load program
 instruction strobes and its pointer on the same clock.
*/
`timescale 1ns/100ps
module spfs_sequencer
   import spfs_pkg::*;
#(
   parameter int PROG_CYC = SPFS_PROG_CYC
) (
   // Clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_nrst,
   // Register port from the CPU core
   input  wire logic                  i_reg_wr,
   input  wire logic [7:0]            i_reg_addr,
   input  wire logic [7:0]            i_reg_wdata,
   output logic      [7:0]            o_reg_rdata,
   // Program instruction port
   input  wire logic                  i_store_instr,
   input  wire logic                  i_load_instr,
   input  wire logic [15:0]           i_flash_ptr,
   input  wire logic [7:0]            i_data_low_reg,
   input  wire logic [7:0]            i_data_high_reg,
   input  wire logic                  i_global_irq_flag,
   output logic                       o_load_override,
   output logic      [7:0]            o_load_data,
   output logic                       o_irq_req,
   output logic                       o_cpu_halt,
   // Flash array side
   input  wire logic [1:0]            i_boot_size_select,
   input  wire logic [7:0]            i_fuse_byte,
   input  wire logic [15:0]           i_flash_rdata,
   output spfs_pkg::spfs_flash_cmd_s  o_flash_cmd,
   output logic      [15:0]           o_buf_rdata_word,
   output logic                       o_app_read_block,
   output logic      [13:0]           o_boot_start,
   output logic      [5:0]            o_boot_pages
);
   import spfs_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic in_stall(input logic [7:0] page);
      in_stall = {page, 6'h00} >= SPFS_STALL_BASE;
   endfunction

   logic                    irq_en;
   logic                    busy;
   logic [4:0]              cmd;
   logic [2:0]              win;
   logic [1:0]              rwin;
   logic                    prog_run;
   logic                    prog_stall;
   logic [22:0]             prog_cnt;
   logic [7:0]              lock_bits;
   logic [15:0]             page_buf [64];
   logic                    loading;
   logic                    csr_wr;
   logic                    pat_ok;
   logic                    store_ok;
   spfs_op_e                op;
   logic [7:0]              ptr_page;
   logic [5:0]              ptr_word;

   assign csr_wr   = i_reg_wr && (i_reg_addr == SPFS_CSR_OFFSET);
   assign pat_ok   = (i_reg_wdata[4:0] == SPFS_PAT_REEN) ||
                     (i_reg_wdata[4:0] == SPFS_PAT_LOCK) ||
                     (i_reg_wdata[4:0] == SPFS_PAT_WRITE) ||
                     (i_reg_wdata[4:0] == SPFS_PAT_ERASE) ||
                     (i_reg_wdata[4:0] == SPFS_PAT_FILL);
   // Pointer bit 15 is never looked at
   assign ptr_page = i_flash_ptr[SPFS_PAGE_LSB +: SPFS_PAGE_W];
   assign ptr_word = i_flash_ptr[SPFS_WORD_LSB +: SPFS_WORD_W];
   assign store_ok = i_store_instr && (win != 3'h0) && !prog_run;

   always_comb begin
      op = SPFS_OP_NONE;
      if (store_ok) begin
         unique case (cmd)
            SPFS_PAT_REEN:  op = SPFS_OP_REEN;
            SPFS_PAT_LOCK:  op = SPFS_OP_LOCK;
            SPFS_PAT_WRITE: op = SPFS_OP_WRITE;
            SPFS_PAT_ERASE: op = SPFS_OP_ERASE;
            default:        op = SPFS_OP_FILL;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Boot partition
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_boot_start <= SPFS_BOOT_00;
         o_boot_pages <= SPFS_PAGES_00;
      end else begin
         unique case (i_boot_size_select)
            2'h3: begin o_boot_start <= SPFS_BOOT_11; o_boot_pages <= SPFS_PAGES_11; end
            2'h2: begin o_boot_start <= SPFS_BOOT_10; o_boot_pages <= SPFS_PAGES_10; end
            2'h1: begin o_boot_start <= SPFS_BOOT_01; o_boot_pages <= SPFS_PAGES_01; end
            2'h0: begin o_boot_start <= SPFS_BOOT_00; o_boot_pages <= SPFS_PAGES_00; end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Command bits and store window
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd <= 5'h00;
         win <= 3'h0;
      end else if (prog_run) begin
         // Enable and op bit stay up until the timer ends
         if (prog_cnt == 23'h000001) begin
            cmd <= 5'h00;
         end
      end else if (csr_wr && pat_ok) begin
         cmd <= i_reg_wdata[4:0];
         win <= 3'(SPFS_WINDOW_CYC);
      end else if (store_ok) begin
         win <= 3'h0;
         if (op != SPFS_OP_ERASE && op != SPFS_OP_WRITE && op != SPFS_OP_LOCK) begin
            cmd <= 5'h00;
         end
      end else if (win != 3'h0) begin
         win <= win - 3'h1;
         if (win == 3'h1) begin
            cmd <= 5'h00;
         end
      end
   end

   // Load read-back window for lock and fuse bits
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rwin <= 2'h0;
      end else if (csr_wr && pat_ok && i_reg_wdata[4:0] == SPFS_PAT_LOCK && !prog_run) begin
         rwin <= 2'(SPFS_READ_WIN_CYC);
      end else if (rwin != 2'h0) begin
         rwin <= rwin - 2'h1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_en <= 1'b0;
      end else if (csr_wr) begin
         irq_en <= i_reg_wdata[SPFS_BIT_IRQEN];
      end
   end

   // ---------------------------------------------------------------
   // Programming timer
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prog_run   <= 1'b0;
         prog_stall <= 1'b0;
         prog_cnt   <= 23'h000000;
         o_flash_cmd <= '0;
      end else begin
         o_flash_cmd.erase <= 1'b0;
         o_flash_cmd.write <= 1'b0;
         o_flash_cmd.lock  <= 1'b0;
         if (prog_run) begin
            prog_cnt <= prog_cnt - 23'h000001;
            if (prog_cnt == 23'h000001) begin
               prog_run   <= 1'b0;
               prog_stall <= 1'b0;
            end
         end else if (op == SPFS_OP_ERASE || op == SPFS_OP_WRITE || op == SPFS_OP_LOCK) begin
            prog_run   <= 1'b1;
            prog_cnt   <= 23'(PROG_CYC);
            prog_stall <= (op != SPFS_OP_LOCK) && in_stall(ptr_page);
            o_flash_cmd.erase     <= (op == SPFS_OP_ERASE);
            o_flash_cmd.write     <= (op == SPFS_OP_WRITE);
            o_flash_cmd.lock      <= (op == SPFS_OP_LOCK);
            o_flash_cmd.page      <= ptr_page;
            o_flash_cmd.lock_data <= i_data_low_reg;
         end
      end
   end

   // Lock bits as held on chip; programmed bits are zero
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lock_bits <= SPFS_LOCK_RESET;
      end else if (op == SPFS_OP_LOCK) begin
         lock_bits <= lock_bits & i_data_low_reg;
      end
   end

   // ---------------------------------------------------------------
   // Section busy
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy <= 1'b0;
      end else if ((op == SPFS_OP_ERASE || op == SPFS_OP_WRITE) && !in_stall(ptr_page)) begin
         busy <= 1'b1;
      end else if (op == SPFS_OP_REEN || op == SPFS_OP_FILL) begin
         busy <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Temporary page buffer
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         loading <= 1'b0;
         for (int i = 0; i < 64; i++) begin
            page_buf[i] <= 16'hffff;
         end
      end else if (op == SPFS_OP_FILL) begin
         loading <= 1'b1;
         page_buf[ptr_word] <= {i_data_high_reg, i_data_low_reg};
      end else if (op == SPFS_OP_WRITE) begin
         loading <= 1'b0;
      end else if (csr_wr && i_reg_wdata[SPFS_BIT_REEN] && loading) begin
         loading <= 1'b0;
         for (int i = 0; i < 64; i++) begin
            page_buf[i] <= 16'hffff;
         end
      end
   end

   // Buffer word for the array, walked by the low pointer bits
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_buf_rdata_word <= 16'h0000;
      end else begin
         o_buf_rdata_word <= page_buf[ptr_word];
      end
   end

   // ---------------------------------------------------------------
   // Reads and outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_load_data <= 8'h00;
      end else if (rwin != 2'h0) begin
         o_load_data <= i_flash_ptr[0] ? i_fuse_byte : lock_bits;
      end else begin
         o_load_data <= i_flash_ptr[0] ? i_flash_rdata[15:8] : i_flash_rdata[7:0];
      end
   end

   assign o_load_override  = i_load_instr && (rwin != 2'h0);
   assign o_reg_rdata      = {irq_en, busy, 1'b0, cmd};
   assign o_irq_req        = irq_en && i_global_irq_flag && !cmd[SPFS_BIT_ENABLE];
   assign o_cpu_halt       = prog_stall;
   assign o_app_read_block = busy;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   win_expire_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (csr_wr && pat_ok && !prog_run) ##1 (!i_store_instr && !(csr_wr && pat_ok))[*4]
      |=> !cmd[0])
      else $error("enable not cleared after unused window");
   enable_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      prog_run |-> cmd[0]) else $error("enable dropped during programming");
   busy_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (op == SPFS_OP_ERASE && !in_stall(ptr_page)) |=> busy)
      else $error("busy not set");
   fill_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (op == SPFS_OP_FILL) |=> !busy) else $error("busy not cleared by fill");
   rsvd_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      o_reg_rdata[SPFS_BIT_RSVD] == 1'b0) else $error("reserved bit nonzero");
   irq_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (irq_en && i_global_irq_flag && !cmd[0]) |-> o_irq_req)
      else $error("ready interrupt missing");
   bad_pat_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (csr_wr && !pat_ok && !prog_run && win == 3'h0) |=> $stable(cmd))
      else $error("illegal pattern acted");
   halt_span_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      $rose(o_cpu_halt) |-> o_cpu_halt[*8]) else $error("halt too short");
   reen_busy_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (prog_run && busy) |=> busy) else $error("busy cleared while programming");
   late_store_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_store_instr && win == 3'h0 && !prog_run) |=> !prog_run)
      else $error("store accepted outside window");
   erase_cmd_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (op == SPFS_OP_ERASE) |=> (o_flash_cmd.erase && o_flash_cmd.page == $past(ptr_page)))
      else $error("erase command not issued to pointer page");
   write_cmd_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (op == SPFS_OP_WRITE) |=> (o_flash_cmd.write && !o_flash_cmd.erase && !o_flash_cmd.lock))
      else $error("page write command not issued");
   lock_cmd_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (op == SPFS_OP_LOCK) |=>
      (o_flash_cmd.lock && o_flash_cmd.lock_data == $past(i_data_low_reg)))
      else $error("lock command data wrong");
   prog_done_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (prog_run && prog_cnt == 23'h000001) |=> (!prog_run && cmd == 5'h00))
      else $error("command bits not cleared at completion");
   app_no_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      ((op == SPFS_OP_ERASE || op == SPFS_OP_WRITE) && !in_stall(ptr_page)) |=> !o_cpu_halt)
      else $error("halt raised for concurrent section");
   stall_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      ((op == SPFS_OP_ERASE || op == SPFS_OP_WRITE) && in_stall(ptr_page)) |=> o_cpu_halt)
      else $error("halt missing for stalling section");
   reen_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (op == SPFS_OP_REEN) |=> !busy)
      else $error("busy not cleared by re-enable");
   load_discard_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (csr_wr && i_reg_wdata[SPFS_BIT_REEN] && loading && op == SPFS_OP_NONE) |=> !loading)
      else $error("buffer load not aborted");
   fuse_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (rwin != 2'h0 && i_flash_ptr[0]) |=> (o_load_data == $past(i_fuse_byte)))
      else $error("fuse byte not returned");
endmodule // spfs_sequencer

/* sim/self_program_flash_sequencer_test.sv */
/*
 Testbench for the sequencer, driven through the CPU core model.
 Assumes PROG_CYC shortened to 20 cycles.
*/
`timescale 1ns/100ps
module self_program_flash_sequencer_test;
   import spfs_pkg::*;
   localparam int PC = 20;
   logic clk, nrst, gie;
   logic [1:0] bsel;
   logic reg_wr, store, load, ld_ovr, irq, halt, rblk;
   logic [7:0] addr, wdata, rdata, lo, hi, ld_data;
   logic [15:0] ptr, bufw;
   logic [13:0] bstart;
   logic [5:0] bpages;
   spfs_flash_cmd_s fcmd;
   int mismatches, n_tests, n_ers, n_wr, n_lk, n_ovr;
   logic [7:0] pg, lkd;

   spfs_cpu_model i_spfs_cpu_model (.i_sys_clk(clk), .o_reg_wr(reg_wr),
      .o_reg_addr(addr), .o_reg_wdata(wdata), .o_store(store), .o_load(load),
      .o_ptr(ptr), .o_lo(lo), .o_hi(hi));
   spfs_sequencer #(.PROG_CYC(PC)) i_spfs_sequencer (.i_sys_clk(clk),
      .i_nrst(nrst), .i_reg_wr(reg_wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .i_store_instr(store), .i_load_instr(load),
      .i_flash_ptr(ptr), .i_data_low_reg(lo), .i_data_high_reg(hi),
      .i_global_irq_flag(gie), .o_load_override(ld_ovr), .o_load_data(ld_data),
      .o_irq_req(irq), .o_cpu_halt(halt), .i_boot_size_select(bsel),
      .i_fuse_byte(8'h5a), .i_flash_rdata(16'h1234), .o_flash_cmd(fcmd),
      .o_buf_rdata_word(bufw), .o_app_read_block(rblk), .o_boot_start(bstart),
      .o_boot_pages(bpages));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Pulse monitor for array commands
   always @(posedge clk) begin
      if (fcmd.erase === 1'b1) n_ers++;
      if (fcmd.write === 1'b1) n_wr++;
      if (fcmd.lock === 1'b1) n_lk++;
      if (fcmd.erase === 1'b1 || fcmd.write === 1'b1) pg = fcmd.page;
      if (fcmd.lock === 1'b1) lkd = fcmd.lock_data;
      if (load === 1'b1 && ld_ovr === 1'b1) n_ovr++;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_boot();
      logic [13:0] st [4] = '{14'h3800, 14'h3c00, 14'h3e00, 14'h3f00};
      logic [5:0]  np [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
      chk("csr reset", 16'h0000, {8'h00, rdata});
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         bsel <= i[1:0];
         cyc(3);
         chk("boot start", {2'b00, st[i]}, {2'b00, bstart});
         chk("boot pages", {10'h000, np[i]}, {10'h000, bpages});
      end
      $display("test reset_boot done");
   endtask

   task automatic t_refused();
      i_spfs_cpu_model.csr_wr(8'h37, 8'h20);
      cyc(1);
      chk("reserved bit", 16'h0000, {8'h00, rdata});
      i_spfs_cpu_model.csr_wr(8'h37, 8'h07);
      cyc(1);
      chk("bad pattern", 16'h0000, {8'h00, rdata});
      i_spfs_cpu_model.csr_wr(8'h38, 8'h01);
      cyc(1);
      chk("unmapped", 16'h0000, {8'h00, rdata});
      i_spfs_cpu_model.csr_wr(8'h37, 8'h03);
      cyc(6);
      chk("window expiry", 16'h0000, {8'h00, rdata});
      i_spfs_cpu_model.spm(16'h0280, 8'h00, 8'h00);
      cyc(3);
      chk("late store", 16'h0000, n_ers[15:0]);
      $display("test refused done");
   endtask

   task automatic t_erase_rww();
      i_spfs_cpu_model.csr_wr(8'h37, 8'h03);
      i_spfs_cpu_model.spm(16'h8280, 8'h11, 8'h22);
      cyc(3);
      chk("erase pulses", 16'h0001, n_ers[15:0]);
      chk("erase page", 16'h0005, {8'h00, pg});
      cyc(6);
      chk("enable held", 16'h0001, {15'h0, rdata[0]});
      chk("busy set", 16'h0001, {15'h0, rdata[6]});
      chk("read block", 16'h0001, {15'h0, rblk});
      chk("no halt rww", 16'h0000, {15'h0, halt});
      i_spfs_cpu_model.csr_wr(8'h37, 8'h11);
      i_spfs_cpu_model.spm(16'h0000, 8'h00, 8'h00);
      cyc(2);
      chk("reen refused", 16'h0001, {15'h0, rdata[6]});
      cyc(PC + 4);
      chk("done clears", 16'h0000, {11'h0, rdata[4:0]});
      chk("busy stays", 16'h0001, {15'h0, rdata[6]});
      i_spfs_cpu_model.csr_wr(8'h37, 8'h11);
      i_spfs_cpu_model.spm(16'h0000, 8'h00, 8'h00);
      cyc(3);
      chk("busy cleared", 16'h0000, {15'h0, rdata[6]});
      chk("block cleared", 16'h0000, {15'h0, rblk});
      $display("test erase_rww done");
   endtask

   task automatic t_fill_write();
      i_spfs_cpu_model.csr_wr(8'h37, 8'h01);
      i_spfs_cpu_model.spm(16'h0007, 8'hc3, 8'h96);
      cyc(3);
      chk("buffer word", 16'h96c3, bufw);
      chk("fill done", 16'h0000, {15'h0, rdata[0]});
      i_spfs_cpu_model.csr_wr(8'h37, 8'h11);
      cyc(6);
      chk("fill discarded", 16'hffff, bufw);
      i_spfs_cpu_model.csr_wr(8'h37, 8'h05);
      i_spfs_cpu_model.spm(16'h7000, 8'h00, 8'h00);
      cyc(4);
      chk("write pulses", 16'h0001, n_wr[15:0]);
      chk("write page", 16'h00e0, {8'h00, pg});
      chk("halt", 16'h0001, {15'h0, halt});
      chk("no busy stalling_section", 16'h0000, {15'h0, rdata[6]});
      cyc(PC + 4);
      chk("halt end", 16'h0000, {15'h0, halt});
      chk("write clear", 16'h0000, {11'h0, rdata[4:0]});
      $display("test fill_write done");
   endtask

   task automatic t_lock_irq();
      i_spfs_cpu_model.csr_wr(8'h37, 8'h09);
      i_spfs_cpu_model.lpm(16'h0001);
      cyc(1);
      chk("fuse read", 16'h005a, {8'h00, ld_data});
      chk("load override", 16'h0001, n_ovr[15:0]);
      i_spfs_cpu_model.csr_wr(8'h37, 8'h09);
      i_spfs_cpu_model.spm(16'h3fff, 8'ha5, 8'hff);
      cyc(3);
      chk("lock pulses", 16'h0001, n_lk[15:0]);
      chk("lock data", 16'h00a5, {8'h00, lkd});
      cyc(PC + 4);
      i_spfs_cpu_model.csr_wr(8'h37, 8'h09);
      i_spfs_cpu_model.lpm(16'h0000);
      cyc(1);
      chk("lock read", 16'h00a5, {8'h00, ld_data});
      chk("lock override", 16'h0002, n_ovr[15:0]);
      repeat (6) @(posedge clk);
      gie <= 1'b1;
      i_spfs_cpu_model.csr_wr(8'h37, 8'h80);
      cyc(1);
      chk("irq on", 16'h0001, {15'h0, irq});
      i_spfs_cpu_model.csr_wr(8'h37, 8'h81);
      cyc(1);
      chk("irq busy", 16'h0000, {15'h0, irq});
      repeat (6) @(posedge clk);
      gie <= 1'b0;
      cyc(1);
      chk("irq gie off", 16'h0000, {15'h0, irq});
      i_spfs_cpu_model.lpm(16'h0001);
      cyc(1);
      chk("flash byte", 16'h0012, {8'h00, ld_data});
      chk("no override", 16'h0002, n_ovr[15:0]);
      $display("test lock_irq done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      mismatches = 0;
      n_tests = 0;
      n_ers = 0;
      n_wr = 0;
      n_lk = 0;
      n_ovr = 0;
      nrst = 1'b0;
      gie = 1'b0;
      bsel = 2'b00;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      cyc(1);
      t_reset_boot();
      t_refused();
      t_erase_rww();
      t_fill_write();
      t_lock_irq();
      tally_and_finish();
   end
endmodule // self_program_flash_sequencer_test

/* sim/spfs_cpu_model.sv */
/*
 CPU core model: register writes, store and load program strobes, pointer
 and data registers. Assumes the sequencer samples on the rising edge.
*/
`timescale 1ns/100ps
module spfs_cpu_model (
   // Clock
   input  wire logic        i_sys_clk,
   // Core outputs
   output logic             o_reg_wr,
   output logic [7:0]       o_reg_addr,
   output logic [7:0]       o_reg_wdata,
   output logic             o_store,
   output logic             o_load,
   output logic [15:0]      o_ptr,
   output logic [7:0]       o_lo,
   output logic [7:0]       o_hi
);
   initial begin
      o_reg_wr    = 1'b0;
      o_reg_addr  = 8'h37;
      o_reg_wdata = 8'h00;
      o_store     = 1'b0;
      o_load      = 1'b0;
      o_ptr       = 16'h0000;
      o_lo        = 8'h00;
      o_hi        = 8'h00;
   end

   // ---------------------------------------------------------------
   // Instructions
   // ---------------------------------------------------------------
   task automatic csr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg_wr    <= 1'b1;
      o_reg_addr  <= a;
      o_reg_wdata <= d;
      @(posedge i_sys_clk);
      o_reg_wr    <= 1'b0;
      o_reg_addr  <= 8'h37;
   endtask

   // Pointer bit 0 kept clear for every store
   task automatic spm(input logic [15:0] p, input logic [7:0] l, input logic [7:0] h);
      @(posedge i_sys_clk);
      o_store <= 1'b1;
      o_ptr   <= {p[15:1], 1'b0};
      o_lo    <= l;
      o_hi    <= h;
      @(posedge i_sys_clk);
      o_store <= 1'b0;
   endtask

   task automatic lpm(input logic [15:0] p);
      @(posedge i_sys_clk);
      o_load <= 1'b1;
      o_ptr  <= p;
      @(posedge i_sys_clk);
      o_load <= 1'b0;
   endtask
endmodule // spfs_cpu_model
